// File: logic/rgrsp_pkg.sv
/*
  Shared constants and types for the registration response payload block:
  octet positions, field bit positions, entry codes, register offsets and
  reset values. Assumes one clock domain and a 32-bit word register port.
*/
// Behaviour
// - Unicast answer to a registration only
// - Octets 0-5 carry requester registration identifier
// - Octet 6 node number, zero if denied
// - Octet 7 bit 0 registration success flag
// - Octet 7 bits 3:1 bandplan group field
// - Octet 7 bits 6:4 rejection code
// - Octet 7 bit 7 security mode flag
// - Octet 8 bits 1:0 echo attempt count
// - Octet 8 bits 4:2 extended rejection code
// - Octet 8 bit 5 controller role fixed
// - Octet 8 bits 7:6 sent zero, ignored
// - Octets 9-15 security field, zero if unsecured
// - Security field: low node number, upper identity
// - Entry octet 0 is type code
// - Entry octet 1 is value length 0-255
// - Value octets 2..L+1, absent when L zero
// - Type 1 contention window, 2 backup controller
// - Backup entry node number, zero if unregistered
// - Backup entry identity, zero if unregistered
package rgrsp_pkg;

  // Payload layout
  localparam int unsigned HDR_LEN = 17;
  localparam logic [4:0] OCT_NODE = 5'h6;
  localparam logic [4:0] OCT_FLAGS = 5'h7;
  localparam logic [4:0] OCT_EXT = 5'h8;
  localparam logic [4:0] OCT_SEC0 = 5'h9;
  localparam logic [4:0] OCT_COUNT = 5'h10;
  localparam logic [4:0] OCT_BK_TYPE = 5'h11;
  localparam logic [4:0] OCT_BK_LAST = 5'h19;

  // Bit positions inside octets 7 and 8
  localparam int unsigned FLAG_BIT = 0;
  localparam int unsigned BAND_LSB = 1;
  localparam int unsigned REJ_LSB = 4;
  localparam int unsigned SECMODE_BIT = 7;
  localparam int unsigned ATT_LSB = 0;
  localparam int unsigned EXTREJ_LSB = 2;
  localparam int unsigned SCFIX_BIT = 5;

  // Entry codes
  localparam logic [7:0] TYPE_CW = 8'h01;
  localparam logic [7:0] TYPE_BACKUP = 8'h02;
  localparam logic [7:0] BK_LEN = 8'h07;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TX_ID_LO = 8'h04;
  localparam logic [7:0] REG_TX_ID_HI = 8'h08;
  localparam logic [7:0] REG_TX_FIELDS = 8'h0C;
  localparam logic [7:0] REG_TX_SEC_LO = 8'h10;
  localparam logic [7:0] REG_TX_SEC_HI = 8'h14;
  localparam logic [7:0] REG_TX_BK_LO = 8'h18;
  localparam logic [7:0] REG_TX_BK_HI = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_RX_ID_LO = 8'h24;
  localparam logic [7:0] REG_RX_ID_HI = 8'h28;
  localparam logic [7:0] REG_RX_FIELDS = 8'h2C;
  localparam logic [7:0] REG_RX_SEC_LO = 8'h30;
  localparam logic [7:0] REG_RX_SEC_HI = 8'h34;
  localparam logic [7:0] REG_RX_BK_LO = 8'h38;
  localparam logic [7:0] REG_RX_BK_HI = 8'h3C;

  // Control and status bits
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_BK_EN = 1;
  localparam int unsigned CTRL_BK_REG = 2;
  localparam int unsigned ST_TX_BUSY = 0;
  localparam int unsigned ST_RX_DONE = 1;
  localparam int unsigned ST_RX_BAD = 2;
  localparam int unsigned ST_BK_SEEN = 3;
  localparam int unsigned ST_CW_SEEN = 4;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Response header fields as software sets them
  typedef struct packed {
    logic [47:0] registration_identifier;
    logic [7:0] node;
    logic flag;
    logic [2:0] band;
    logic [2:0] rej;
    logic secmode;
    logic [1:0] attempt;
    logic [2:0] extrej;
    logic scfix;
    logic [7:0] sec_node;
    logic [47:0] sec_id;
  } rgrsp_hdr_s;

endpackage : rgrsp_pkg

// File: logic/rgrsp_tx_if.sv
/*
  Carrier between the register/parser top and the response builder.
  Assumes both ends run on the same clock.
*/
interface rgrsp_tx_if;
  import rgrsp_pkg::*;
  logic start;
  rgrsp_hdr_s hdr;
  logic bk_en;
  logic bk_reg;
  logic [7:0] bk_node;
  logic [47:0] bk_id;
  logic busy;
  logic [7:0] data;
  logic valid;
  logic last;
  logic ready;
  modport builder (input start, hdr, bk_en, bk_reg, bk_node, bk_id, ready,
                   output busy, data, valid, last);
  modport ctrl (output start, hdr, bk_en, bk_reg, bk_node, bk_id, ready,
                input busy, data, valid, last);
endinterface : rgrsp_tx_if

// File: logic/rgrsp_builder.sv
/*
  Response builder: emits the payload octet by octet on a valid/ready
  stream. Assumes fields hold still while busy is high.
*/
module rgrsp_builder
  import rgrsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control side
  rgrsp_tx_if.builder tx
);
  import rgrsp_pkg::*;

  logic [4:0] idx;
  logic [4:0] last_idx;

  // Octet at a given payload position; all zeroing done here
  function automatic logic [7:0] octet_at(input logic [4:0] i, input rgrsp_hdr_s h,
      input logic bk_en, input logic bk_reg, input logic [7:0] bk_node,
      input logic [47:0] bk_id);
    logic [55:0] sec;
    logic [7:0] o;
    sec = h.secmode ? {h.sec_id, h.sec_node} : 56'h00_0000_0000_0000;
    o = 8'h00;
    if (i < OCT_NODE) begin
      o = h.registration_identifier[8'd47 - 8'd8 * i -: 8];
    end else if (i == OCT_NODE) begin
      o = h.flag ? h.node : 8'h00;
    end else if (i == OCT_FLAGS) begin
      o = {h.secmode, h.rej, h.band, h.flag};
    end else if (i == OCT_EXT) begin
      o = {2'b00, h.scfix, h.extrej, h.attempt};
    end else if (i < OCT_COUNT) begin
      o = sec[8'd55 - 8'd8 * (i - OCT_SEC0) -: 8];
    end else if (i == OCT_COUNT) begin
      o = {7'h00, bk_en};
    end else if (i == OCT_BK_TYPE) begin
      o = TYPE_BACKUP;
    end else if (i == OCT_BK_TYPE + 5'd1) begin
      o = BK_LEN;
    end else if (i == OCT_BK_TYPE + 5'd2) begin
      o = bk_reg ? bk_node : 8'h00;
    end else begin
      o = bk_reg ? bk_id[8'd47 - 8'd8 * (i - OCT_BK_TYPE - 5'd3) -: 8] : 8'h00;
    end
    return o;
  endfunction

  assign last_idx = tx.bk_en ? OCT_BK_LAST : OCT_COUNT;

  // Stream walker; a new octet loads only when the slot is free
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idx <= 5'h00;
      tx.busy <= 1'b0;
      tx.valid <= 1'b0;
      tx.last <= 1'b0;
      tx.data <= 8'h00;
    end else if (!tx.busy) begin
      if (tx.start) begin
        tx.busy <= 1'b1;
        idx <= 5'h00;
      end
    end else if (!tx.valid || tx.ready) begin
      if (tx.valid && tx.last) begin
        tx.busy <= 1'b0;
        tx.valid <= 1'b0;
        tx.last <= 1'b0;
      end else begin
        tx.valid <= 1'b1;
        tx.data <= octet_at(idx, tx.hdr, tx.bk_en, tx.bk_reg, tx.bk_node, tx.bk_id);
        tx.last <= (idx == last_idx);
        idx <= idx + 5'd1;
      end
    end
  end

endmodule : rgrsp_builder

// File: logic/rgrsp_top.sv
/*
  Registration response payload block: register port, response builder
  (domain master role) and payload parser (registering node role).
  Assumes the receive stream comes from logic on MCLK and that the
  message type was already decoded upstream, so every octet seen here
  belongs to a registration response payload.
*/
// The strobed register port and the register offsets were chosen for this implementation.
module rgrsp_top
  import rgrsp_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Transmit payload stream
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  output logic TX_LAST,
  input wire logic TX_READY,
  // Receive payload stream
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_LAST
);
  import rgrsp_pkg::*;

  typedef enum logic [2:0] {P_HDR, P_TYPE, P_LEN, P_VAL, P_TAIL} rgrsp_pstate_e;

  rgrsp_tx_if txi ();

  // Transmit-side registers
  rgrsp_hdr_s tx_hdr;
  logic tx_bk_en;
  logic tx_bk_reg;
  logic [7:0] tx_bk_node;
  logic [47:0] tx_bk_id;
  logic tx_start;

  // Receive-side state
  logic [7:0] rx_oct [0:HDR_LEN-1];
  rgrsp_pstate_e pstate;
  rgrsp_pstate_e next_pstate;
  logic [4:0] hidx;
  logic [7:0] entries_left;
  logic [7:0] cur_type;
  logic [7:0] vlen;
  logic [7:0] vidx;
  logic [7:0] rx_count;
  logic [7:0] rx_bk_node;
  logic [47:0] rx_bk_id;
  logic [7:0] skipped;
  logic rx_done;
  logic rx_bad;
  logic bk_seen;
  logic cw_seen;
  logic entry_end;
  logic msg_end;
  logic msg_bad;

  // Strobes of the register port and receive field views
  logic wr_ctrl;
  logic wr_status;
  logic [47:0] rx_registration_identifier;
  logic [55:0] rx_sec;

  // Field word layout shared by the transmit and receive readback
  function automatic logic [31:0] fields_word(input logic [7:0] node, input logic flag,
      input logic [2:0] band, input logic [2:0] rej, input logic secmode,
      input logic [1:0] attempt, input logic [2:0] extrej, input logic scfix);
    return {10'h000, scfix, extrej, attempt, secmode, rej, band, flag, node};
  endfunction

  // Builder instance
  rgrsp_builder u_builder (
    .clk(MCLK),
    .reset_n(RESET_N),
    .tx(txi)
  );

  assign txi.start = tx_start;
  assign txi.hdr = tx_hdr;
  assign txi.bk_en = tx_bk_en;
  assign txi.bk_reg = tx_bk_reg;
  assign txi.bk_node = tx_bk_node;
  assign txi.bk_id = tx_bk_id;
  assign txi.ready = TX_READY;
  assign TX_DATA = txi.data;
  assign TX_VALID = txi.valid;
  assign TX_LAST = txi.last;

  assign wr_ctrl = WR && (ADDR == REG_CTRL);
  assign wr_status = WR && (ADDR == REG_STATUS);

  // Start is a one-cycle pulse; ignored by the builder while busy
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_start <= 1'b0;
    end else begin
      tx_start <= wr_ctrl && WDATA[CTRL_START];
    end
  end

  // Transmit field registers
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_hdr <= '0;
      tx_bk_en <= 1'b0;
      tx_bk_reg <= 1'b0;
      tx_bk_node <= 8'h00;
      tx_bk_id <= 48'h0000_0000_0000;
    end else if (WR) begin
      unique case (ADDR)
        REG_CTRL: begin
          tx_bk_en <= WDATA[CTRL_BK_EN];
          tx_bk_reg <= WDATA[CTRL_BK_REG];
        end
        REG_TX_ID_LO: tx_hdr.registration_identifier[31:0] <= WDATA;
        REG_TX_ID_HI: tx_hdr.registration_identifier[47:32] <= WDATA[15:0];
        REG_TX_FIELDS: begin
          tx_hdr.node <= WDATA[7:0];
          tx_hdr.flag <= WDATA[8];
          tx_hdr.band <= WDATA[11:9];
          tx_hdr.rej <= WDATA[14:12];
          tx_hdr.secmode <= WDATA[15];
          tx_hdr.attempt <= WDATA[17:16];
          tx_hdr.extrej <= WDATA[20:18];
          tx_hdr.scfix <= WDATA[21];
        end
        REG_TX_SEC_LO: tx_hdr.sec_id[31:0] <= WDATA;
        REG_TX_SEC_HI: begin
          tx_hdr.sec_id[47:32] <= WDATA[15:0];
          tx_hdr.sec_node <= WDATA[23:16];
        end
        REG_TX_BK_LO: tx_bk_id[31:0] <= WDATA;
        REG_TX_BK_HI: begin
          tx_bk_id[47:32] <= WDATA[15:0];
          tx_bk_node <= WDATA[23:16];
        end
        default: ;
      endcase
    end
  end

  // Parser next state and end-of-entry decode
  always_comb begin
    next_pstate = pstate;
    entry_end = 1'b0;
    unique case (pstate)
      P_HDR: begin
        if (hidx == OCT_COUNT) begin
          next_pstate = (RX_DATA == 8'h00) ? P_TAIL : P_TYPE;
        end
      end
      P_TYPE: next_pstate = P_LEN;
      P_LEN: begin
        if (RX_DATA == 8'h00) begin
          entry_end = 1'b1;
        end else begin
          next_pstate = P_VAL;
        end
      end
      P_VAL: entry_end = (vidx == vlen);
      P_TAIL: next_pstate = P_TAIL;
    endcase
    if (entry_end) begin
      next_pstate = (entries_left == 8'h01) ? P_TAIL : P_TYPE;
    end
  end

  // A payload is bad if it ends before the final entry closes; octets after it are ignored
  assign msg_end = RX_VALID && RX_LAST;
  assign msg_bad = msg_end && (next_pstate != P_TAIL);

  // Parser walk; the state returns to the header at each end of message
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pstate <= P_HDR;
      hidx <= 5'h00;
      entries_left <= 8'h00;
      cur_type <= 8'h00;
      vlen <= 8'h00;
      vidx <= 8'h00;
    end else if (RX_VALID) begin
      pstate <= msg_end ? P_HDR : next_pstate;
      hidx <= msg_end ? 5'h00 : ((pstate == P_HDR) ? hidx + 5'd1 : hidx);
      if (pstate == P_HDR && hidx == OCT_COUNT) begin
        entries_left <= RX_DATA;
      end else if (entry_end) begin
        entries_left <= entries_left - 8'd1;
      end
      if (pstate == P_TYPE) begin
        cur_type <= RX_DATA;
      end
      if (pstate == P_LEN) begin
        vlen <= RX_DATA;
        vidx <= 8'h01;
      end else if (pstate == P_VAL) begin
        vidx <= vidx + 8'd1;
      end
    end
  end

  // Header octets kept raw; decoding happens at readback
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < HDR_LEN; i++) begin
        rx_oct[i] <= 8'h00;
      end
    end else if (RX_VALID && pstate == P_HDR) begin
      rx_oct[hidx] <= RX_DATA;
    end
  end

  // Backup controller entry capture; value octets counted from one
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_bk_node <= 8'h00;
      rx_bk_id <= 48'h0000_0000_0000;
      rx_count <= 8'h00;
    end else if (RX_VALID) begin
      if (pstate == P_HDR && hidx == OCT_COUNT) begin
        rx_count <= RX_DATA;
      end
      if (pstate == P_VAL && cur_type == TYPE_BACKUP) begin
        if (vidx == 8'h01) begin
          rx_bk_node <= RX_DATA;
        end else if (vidx <= BK_LEN) begin
          rx_bk_id[8'd63 - 8'd8 * vidx -: 8] <= RX_DATA;
        end
      end
    end
  end

  // Status flags: hardware set wins over a write-one clear
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_done <= 1'b0;
      rx_bad <= 1'b0;
      bk_seen <= 1'b0;
      cw_seen <= 1'b0;
      skipped <= 8'h00;
    end else begin
      rx_done <= msg_end || (rx_done && !(wr_status && WDATA[ST_RX_DONE]));
      rx_bad <= msg_bad || (rx_bad && !(wr_status && WDATA[ST_RX_BAD]));
      if (RX_VALID && pstate == P_HDR && hidx == 5'h00) begin
        bk_seen <= 1'b0;
        cw_seen <= 1'b0;
        skipped <= 8'h00;
      end else if (RX_VALID && pstate == P_LEN) begin
        // Reserved types only counted, never an error
        unique case (cur_type)
          TYPE_CW: cw_seen <= 1'b1;
          TYPE_BACKUP: bk_seen <= 1'b1;
          default: skipped <= skipped + 8'd1;
        endcase
      end
    end
  end

  // Receive field views; octet 8 reserved bits dropped
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      rx_registration_identifier[47 - 8 * i -: 8] = rx_oct[i];
    end
    for (int i = 0; i < 7; i++) begin
      rx_sec[55 - 8 * i -: 8] = rx_oct[9 + i];
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= RST_WORD;
    end else if (!RD) begin
      RDATA <= RST_WORD;
    end else begin
      unique case (ADDR)
        REG_CTRL: RDATA <= {29'h000_0000, tx_bk_reg, tx_bk_en, 1'b0};
        REG_TX_ID_LO: RDATA <= tx_hdr.registration_identifier[31:0];
        REG_TX_ID_HI: RDATA <= {16'h0000, tx_hdr.registration_identifier[47:32]};
        REG_TX_FIELDS: RDATA <= fields_word(tx_hdr.node, tx_hdr.flag, tx_hdr.band,
            tx_hdr.rej, tx_hdr.secmode, tx_hdr.attempt, tx_hdr.extrej, tx_hdr.scfix);
        REG_TX_SEC_LO: RDATA <= tx_hdr.sec_id[31:0];
        REG_TX_SEC_HI: RDATA <= {8'h00, tx_hdr.sec_node, tx_hdr.sec_id[47:32]};
        REG_TX_BK_LO: RDATA <= tx_bk_id[31:0];
        REG_TX_BK_HI: RDATA <= {8'h00, tx_bk_node, tx_bk_id[47:32]};
        REG_STATUS: RDATA <= {16'h0000, skipped, 3'b000, cw_seen, bk_seen, rx_bad,
            rx_done, txi.busy};
        REG_RX_ID_LO: RDATA <= rx_registration_identifier[31:0];
        REG_RX_ID_HI: RDATA <= {16'h0000, rx_registration_identifier[47:32]};
        REG_RX_FIELDS: RDATA <= fields_word(rx_oct[OCT_NODE],
            rx_oct[OCT_FLAGS][FLAG_BIT], rx_oct[OCT_FLAGS][BAND_LSB +: 3],
            rx_oct[OCT_FLAGS][REJ_LSB +: 3], rx_oct[OCT_FLAGS][SECMODE_BIT],
            rx_oct[OCT_EXT][ATT_LSB +: 2], rx_oct[OCT_EXT][EXTREJ_LSB +: 3],
            rx_oct[OCT_EXT][SCFIX_BIT]);
        REG_RX_SEC_LO: RDATA <= rx_sec[39:8];
        REG_RX_SEC_HI: RDATA <= {8'h00, rx_sec[7:0], rx_sec[55:40]};
        REG_RX_BK_LO: RDATA <= rx_bk_id[31:0];
        REG_RX_BK_HI: RDATA <= {rx_count, rx_bk_node, rx_bk_id[47:32]};
        default: RDATA <= RST_WORD;
      endcase
    end
  end

endmodule : rgrsp_top

// File: dv/rgrsp_assertions.sv
/*
  Checker for the registration response block: watches the transmit
  stream at the top ports. Assumes one clock, async active-low reset.
*/
module rgrsp_assertions
  import rgrsp_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // Transmit stream
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_LAST,
  input wire logic TX_READY
);
  timeunit 1ns;
  timeprecision 1ps;
  import rgrsp_pkg::*;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  logic acc;
  logic [4:0] idx;
  logic [7:0] node_oct;
  logic sec_on;
  assign acc = TX_VALID && TX_READY;
  // Octet position in the message, back to zero after the last one
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) idx <= 5'h0;
    else if (acc) idx <= TX_LAST ? 5'h0 : idx + 5'h1;
  end
  // Keep node number and security mode for later octets
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      node_oct <= 8'h00;
      sec_on <= 1'b0;
    end else if (acc && idx == OCT_NODE) node_oct <= TX_DATA;
    else if (acc && idx == OCT_FLAGS) sec_on <= TX_DATA[SECMODE_BIT];
  end
  property p_hold;
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST);
  endproperty
  a_hold: assert property (p_hold) else $error("tx octet changed while stalled");
  property p_drop;
    acc && TX_LAST |=> !TX_VALID;
  endproperty
  a_drop: assert property (p_drop) else $error("tx valid after last octet");
  property p_count;
    TX_VALID && idx == OCT_COUNT |-> TX_LAST == (TX_DATA == 8'h00);
  endproperty
  a_count: assert property (p_count) else $error("entry count and end disagree");
  property p_resv;
    TX_VALID && idx == OCT_EXT |-> TX_DATA[7:6] == 2'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");
  property p_denied;
    TX_VALID && idx == OCT_FLAGS && !TX_DATA[FLAG_BIT] |-> node_oct == 8'h00;
  endproperty
  a_denied: assert property (p_denied) else $error("node number set when denied");
  property p_unsec;
    TX_VALID && idx >= OCT_SEC0 && idx < OCT_COUNT && !sec_on |-> TX_DATA == 8'h00;
  endproperty
  a_unsec: assert property (p_unsec) else $error("security field not zero");
  property p_type;
    TX_VALID && idx == OCT_BK_TYPE |-> TX_DATA == TYPE_BACKUP && !TX_LAST;
  endproperty
  a_type: assert property (p_type) else $error("wrong entry type");
  property p_len;
    TX_VALID && idx == 5'h12 |-> TX_DATA == BK_LEN && !TX_LAST;
  endproperty
  a_len: assert property (p_len) else $error("wrong entry length");
  property p_bk_end;
    TX_VALID && idx == OCT_BK_LAST |-> TX_LAST;
  endproperty
  a_bk_end: assert property (p_bk_end) else $error("entry not ended at length");
endmodule // rgrsp_assertions

// File: dv/rgrsp_peer.sv
/*
  Peer node model: sinks the transmit stream, stalling every other cycle
  when asked, and sources receive messages. Assumes the same clock.
*/
module rgrsp_peer (
  // Clock
  input wire logic MCLK,
  // Transmit stream sink
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_LAST,
  output logic TX_READY,
  // Receive stream source
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  output logic RX_LAST,
  // Test control
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  initial begin
    TX_READY = 1'b0;
    RX_DATA = 8'h00;
    RX_VALID = 1'b0;
    RX_LAST = 1'b0;
  end
  // Collect accepted octets; a slow peer halves the accept rate
  always @(posedge MCLK) begin
    if (TX_VALID && TX_READY) got.push_back(TX_DATA);
    TX_READY <= slow ? ~TX_READY : 1'b1;
  end
  // One octet a cycle, back to back; idle data inverted so it never looks held
  task automatic send(input logic [7:0] m[$]);
    for (int k = 0; k < m.size(); k++) begin
      @(posedge MCLK);
      RX_DATA <= m[k];
      RX_VALID <= 1'b1;
      RX_LAST <= (k == m.size() - 1);
    end
    @(posedge MCLK);
    RX_VALID <= 1'b0;
    RX_LAST <= 1'b0;
    RX_DATA <= ~m[m.size() - 1];
  endtask
endmodule // rgrsp_peer

// File: dv/testbench.sv
/*
  Testbench for the registration response block: register tasks, build
  and parse scenarios. Assumes the peer model and checker files.
*/
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
module testbench
  import rgrsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 1'b0, RESET_N = 1'b0, WR = 1'b0, RD = 1'b0, slow = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0000_0000;
  logic [31:0] RDATA, v;
  logic [7:0] TX_DATA, RX_DATA;
  logic TX_VALID, TX_LAST, TX_READY, RX_VALID, RX_LAST;
  logic [47:0] id, sid, bid;
  logic [55:0] sec;
  logic [7:0] nd, snd, bnd;
  logic fl, sm, fx, bke, bkr;
  logic [2:0] bd, rj, xr;
  logic [1:0] at;
  logic [7:0] e[$];
  int error_cnt = 0;
  int checks = 0;
  always #5 MCLK = ~MCLK;
  rgrsp_top i_rgrsp_top (.MCLK(MCLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
    .TX_LAST(TX_LAST), .TX_READY(TX_READY), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
    .RX_LAST(RX_LAST));
  rgrsp_peer i_rgrsp_peer (.MCLK(MCLK), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
    .TX_LAST(TX_LAST), .TX_READY(TX_READY), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
    .RX_LAST(RX_LAST), .slow(slow));
  // Register port cycles, strobes one cycle long
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  // Fixed header octets 0 to 15 from the field variables
  task automatic hdr;
    e.delete();
    sec = {sid, snd};
    for (int i = 5; i >= 0; i--) e.push_back(id[i*8+:8]);
    e.push_back(fl ? nd : 8'h00);
    e.push_back({sm, rj, bd, fl});
    e.push_back({2'h0, fx, xr, at});
    for (int i = 6; i >= 0; i--) e.push_back(sm ? sec[i*8+:8] : 8'h00);
  endtask
  // Program, start, collect and compare one built message
  task automatic do_tx;
    hdr();
    e.push_back({7'h0, bke});
    if (bke) begin
      e = {e, TYPE_BACKUP, BK_LEN, bkr ? bnd : 8'h00};
      for (int i = 5; i >= 0; i--) e.push_back(bkr ? bid[i*8+:8] : 8'h00);
    end
    wr(REG_TX_ID_LO, id[31:0]);
    wr(REG_TX_ID_HI, {16'h0000, id[47:32]});
    wr(REG_TX_FIELDS, {10'h000, fx, xr, at, sm, rj, bd, fl, nd});
    wr(REG_TX_SEC_LO, sid[31:0]);
    wr(REG_TX_SEC_HI, {8'h00, snd, sid[47:32]});
    wr(REG_TX_BK_LO, bid[31:0]);
    wr(REG_TX_BK_HI, {8'h00, bnd, bid[47:32]});
    i_rgrsp_peer.got.delete();
    wr(REG_CTRL, {29'h000_0000, bkr, bke, 1'b1});
    rd(REG_STATUS, v);
    `CHK("tx busy", 1'b1, v[ST_TX_BUSY])
    for (int k = 0; k < 300 && i_rgrsp_peer.got.size() < e.size(); k++) @(posedge MCLK);
    repeat (4) @(posedge MCLK);
    `CHK("tx length", e.size(), i_rgrsp_peer.got.size())
    foreach (e[k]) `CHK("tx octet", e[k], i_rgrsp_peer.got[k])
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Cut a hang short well after the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge MCLK);
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge MCLK);
    RESET_N <= 1'b1;
    rd(REG_STATUS, v);
    `CHK("status reset", RST_WORD, v)
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, v);
    `CHK("unmapped", 32'h0000_0000, v)
    // Granted, secured, registered backup entry, stalling peer
    id = 48'h0123_4567_89ab; nd = 8'h2a; fl = 1'b1; bd = 3'h5; rj = 3'h0; sm = 1'b1;
    at = 2'h3; xr = 3'h0; fx = 1'b1; snd = 8'h11; sid = 48'hdead_beef_0042;
    bke = 1'b1; bkr = 1'b1; bnd = 8'h33; bid = 48'hcafe_f00d_1234; slow = 1'b1;
    do_tx();
    // Denied and unsecured: stale node and security values must not leak
    for (int a = 0; a < 3; a++) begin
      at = a[1:0]; fl = 1'b0; sm = 1'b0; rj = 3'h7; xr = 3'h5; fx = 1'b0;
      bke = (a == 1); bkr = 1'b0; slow = 1'b0;
      do_tx();
    end
    // Parse: reserved bits set, reserved, window and backup entries
    fl = 1'b1; sm = 1'b1; at = 2'h1; rj = 3'h2; xr = 3'h3; fx = 1'b1;
    hdr();
    e[8] = e[8] | 8'hc0;
    e = {e, 8'h03, 8'h00, 8'h00, 8'h01, 8'h02, 8'haa, 8'h55, TYPE_BACKUP, BK_LEN, bnd};
    for (int i = 5; i >= 0; i--) e.push_back(bid[i*8+:8]);
    i_rgrsp_peer.send(e);
    repeat (2) @(posedge MCLK);
    rd(REG_STATUS, v);
    `CHK("rx status", 32'h0000_011a, v)
    rd(REG_RX_ID_LO, v);
    `CHK("rx id lo", id[31:0], v)
    rd(REG_RX_ID_HI, v);
    `CHK("rx id hi", {16'h0000, id[47:32]}, v)
    rd(REG_RX_SEC_LO, v);
    `CHK("rx sec lo", sid[31:0], v)
    rd(REG_RX_SEC_HI, v);
    `CHK("rx sec hi", {8'h00, snd, sid[47:32]}, v)
    rd(REG_RX_FIELDS, v);
    `CHK("rx fields", {10'h000, fx, xr, at, sm, rj, bd, fl, nd}, v)
    rd(REG_RX_BK_LO, v);
    `CHK("rx backup lo", bid[31:0], v)
    rd(REG_RX_BK_HI, v);
    `CHK("rx backup hi", {8'h03, bnd, bid[47:32]}, v)
    // Entry cut short by the end of the payload
    wr(REG_STATUS, 32'h0000_0006);
    hdr();
    e = {e, 8'h01, TYPE_BACKUP, BK_LEN, bnd};
    i_rgrsp_peer.send(e);
    repeat (2) @(posedge MCLK);
    rd(REG_STATUS, v);
    `CHK("rx malformed", 1'b1, v[ST_RX_BAD])
    // Clean message after clearing: done only
    wr(REG_STATUS, 32'h0000_0006);
    hdr();
    e.push_back(8'h00);
    i_rgrsp_peer.send(e);
    repeat (2) @(posedge MCLK);
    rd(REG_STATUS, v);
    `CHK("rx clean", 2'h1, v[2:1])
    wrap_up();
  end
endmodule // testbench
bind rgrsp_top rgrsp_assertions i_rgrsp_assertions (.MCLK(MCLK), .RESET_N(RESET_N),
  .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_LAST(TX_LAST), .TX_READY(TX_READY));
